// >>> bench/adc_host_model.sv
// Host partner: start pulses, select, read strobe, byte select, serial rx.
// Assumes the port's pins are sampled on rising clk edges.
module adc_host_model (
  // Clock and device pins
  input  wire logic        clk,
  input  wire logic [13:0] pins,
  input  wire logic [13:0] pins_oe_n,
  // Host drive
  output logic             conv_start,
  output logic             sel_n,
  output logic             rd_n,
  output logic             hbs,
  output logic             ext_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Host behaviour
  // ****************************************
  logic div;

  initial begin
    conv_start = 1'b0;
    sel_n      = 1'b1;
    rd_n       = 1'b1;
    hbs        = 1'b0;
    ext_clk    = 1'b0;
    div        = 1'b0;
  end

  // External clock at a quarter of clk, slow enough for a synchroniser
  always @(posedge clk) begin
    div <= ~div;
    if (div) begin
      ext_clk <= ~ext_clk;
    end
  end

  // Five-cycle pulse; select and strobe stay high all along
  task automatic start_pulse;
    @(posedge clk);
    conv_start <= 1'b1;
    repeat (5) @(posedge clk);
    conv_start <= 1'b0;
  endtask

  // One-cycle select low while convert start rests low
  task automatic sel_pulse;
    @(posedge clk);
    sel_n <= 1'b0;
    @(posedge clk);
    sel_n <= 1'b1;
  endtask

  // Both strobes low, data taken one edge after the port sees them
  task automatic read(input logic hb, output logic [13:0] d, output logic [13:0] oe);
    @(posedge clk);
    hbs   <= hb;
    sel_n <= 1'b0;
    rd_n  <= 1'b0;
    repeat (2) @(posedge clk);
    d     = pins;
    oe    = pins_oe_n;
    sel_n <= 1'b1;
    rd_n  <= 1'b1;
  endtask

  // Bits taken at falling serial clock while frame is low; floating data reads x
  task automatic rx_serial(output logic [13:0] w, output logic ok);
    int   n;
    int   b;
    logic prev;
    n    = 0;
    b    = 0;
    w    = 14'h0000;
    prev = 1'b0;
    while (b < 14 && n < 600) begin
      @(posedge clk);
      n++;
      if (pins[12] === 1'b0 && pins_oe_n[12] === 1'b0 && prev === 1'b1 && pins[11] === 1'b0) begin
        w = {w[12:0], (pins_oe_n[10] === 1'b0) ? pins[10] : 1'bx};
        b++;
      end
      prev = pins[11];
    end
    ok = (b == 14);
  endtask
endmodule

// >>> bench/test_adc_conversion_start_and_output_port.sv
// Self-checking bench for the converter start and output port.
// Assumes the package, header, design and host model are compiled first.
`include "adc_port_cfg.svh"
module test_adc_conversion_start_and_output_port
  import adc_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Signals and instances
  // ****************************************
  typedef struct packed {result_t smp; logic hb; logic [7:0] exp;} row_s;
  row_s        rows [4] = '{'{14'h2ABC, 1'b0, 8'hBC}, '{14'h1F5A, 1'b1, 8'h1F},
                            '{14'h3FFF, 1'b1, 8'h3F}, '{14'h2001, 1'b0, 8'h01}};
  logic        mclk;
  logic        rst;
  logic [1:0]  fmt;
  result_t     smp;
  logic [3:0]  av_addr;
  logic        av_rd;
  logic        av_wr;
  logic [31:0] av_wdata;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        conv_start;
  logic        sel_n;
  logic        rd_n;
  logic        hbs;
  logic        ext_clk;
  logic [13:0] dout;
  logic [13:0] dout_oe_n;
  logic        busy_n;
  int          num_errors;
  int          compares;
  int          n;
  logic        prev;
  logic        ok;
  logic [31:0] q;
  logic [13:0] d;
  logic [13:0] oe;

  adc_port i_adc_port (
    .MCLK(mclk), .RST(rst), .CONVERT_START_IN(conv_start), .SELECT_N(sel_n),
    .READ_STROBE_N(rd_n), .FORMAT_SELECT(fmt), .EXT_CLK_IN(ext_clk),
    .MSB_OR_BYTE_SELECT_PIN_I(hbs), .SAMPLE_IN(smp), .DATA_O(dout), .DATA_OE_N(dout_oe_n),
    .BUSY_INT_N(busy_n), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd), .AVS_WRITE(av_wr),
    .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(av_wdata), .AVS_READDATA(av_rdata),
    .AVS_WAITREQUEST(av_wait)
  );
  adc_host_model i_adc_host_model (
    .clk(mclk), .pins(dout), .pins_oe_n(dout_oe_n), .conv_start(conv_start),
    .sel_n(sel_n), .rd_n(rd_n), .hbs(hbs), .ext_clk(ext_clk)
  );

  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic summarize;
    if (num_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until waitrequest is sampled low; data taken at that edge
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    int k;
    @(posedge mclk);
    av_addr  <= a;
    av_wdata <= wd;
    av_wr    <= wr;
    av_rd    <= ~wr;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (av_wait !== 1'b0 && k < 50);
    rd = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    if (av_wait !== 1'b0) begin
      chk("avalon_wait", av_wait, 1'b0);
      summarize();
    end
  endtask

  // Bounded wait for the end of a conversion
  task automatic wait_idle;
    int k;
    k = 0;
    while (busy_n !== 1'b1 && k < 300) begin
      @(posedge mclk);
      k++;
    end
    if (busy_n !== 1'b1) begin
      chk("busy_end", busy_n, 1'b1);
      summarize();
    end
  endtask

  task automatic convert;
    i_adc_host_model.start_pulse();
    chk("busy_start", busy_n, 1'b0);
    wait_idle();
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst        = 1'b1;
    fmt        = `FMT_BYTE;
    smp        = 14'h0000;
    av_addr    = 4'h0;
    av_rd      = 1'b0;
    av_wr      = 1'b0;
    av_wdata   = 32'h0;
    num_errors = 0;
    compares   = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // Byte and serial rows, gated serial clock
    foreach (rows[i]) begin
      smp <= rows[i].smp;
      convert();
      i_adc_host_model.rx_serial(d, ok);
      chk("serial_ok", ok, 1'b1);
      chk("serial_word", d, rows[i].smp);
      i_adc_host_model.read(rows[i].hb, d, oe);
      chk("byte", d[7:0], rows[i].exp);
      chk("byte_oe", oe[7:0], 8'h00);
      av(1'b0, `OFS_RESULT, 32'h0, q);
      chk("result", q[13:0], rows[i].smp);
      chk("sclk_float", dout_oe_n[11], 1'b1);
    end
    // Full-width word and pin release
    fmt <= `FMT_PARALLEL;
    smp <= 14'h2D5B;
    convert();
    i_adc_host_model.read(1'b0, d, oe);
    chk("parallel", d, 14'h2D5B);
    chk("parallel_oe", oe, 14'h0000);
    repeat (3) @(posedge mclk);
    chk("released_oe", dout_oe_n, 14'h3FFF);
    // Start by falling select with convert start low
    av(1'b1, `OFS_CTRL, 32'h5, q);
    i_adc_host_model.sel_pulse();
    repeat (4) @(posedge mclk);
    chk("sel_start", busy_n, 1'b0);
    wait_idle();
    // Start by register write; status and held sample read while busy
    av(1'b1, `OFS_CTRL, 32'h3, q);
    repeat (2) @(posedge mclk);
    chk("soft_start", busy_n, 1'b0);
    av(1'b0, `OFS_STATUS, 32'h0, q);
    chk("status", q, {26'h0, `FMT_PARALLEL, 4'h1});
    av(1'b0, `OFS_SAMPLE, 32'h0, q);
    chk("sample", q[13:0], 14'h2D5B);
    wait_idle();
    av(1'b0, `OFS_CTRL, 32'h0, q);
    chk("soft_clear", q[2:0], 3'h1);
    // External conversion clock
    av(1'b1, `OFS_CTRL, 32'h0, q);
    av(1'b0, `OFS_CTRL, 32'h0, q);
    chk("ctrl_rw", q[2:0], 3'h0);
    smp <= 14'h0ABC;
    convert();
    av(1'b0, `OFS_RESULT, 32'h0, q);
    chk("ext_result", q[13:0], 14'h0ABC);
    // Continuous serial clock keeps toggling
    av(1'b1, `OFS_CTRL, 32'h1, q);
    fmt <= `FMT_CONT;
    n = 0;
    prev = 1'b0;
    repeat (40) begin
      @(posedge mclk);
      if (dout_oe_n[11] === 1'b0 && dout[11] !== prev) n++;
      prev = dout[11];
    end
    chk("sclk_runs", n >= 6, 1'b1);
    av(1'b0, 4'h1, 32'h0, q);
    chk("unmapped", q, 32'h0);
    // Reset in mid-conversion
    i_adc_host_model.start_pulse();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("reset_busy", busy_n, 1'b1);
    chk("reset_oe", dout_oe_n, 14'h3FFF);
    rst <= 1'b0;
    av(1'b0, `OFS_CTRL, 32'h0, q);
    chk("ctrl_reset", q[2:0], `CTRL_RESET);
    summarize();
  end
endmodule

// >>> common/adc_port_cfg.svh
// Constants for the converter start and output port: offsets, fields, resets, timing.
// Assumes a single 100 MHz clock and a byte-addressed Avalon-MM register slave.
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL        4'h0
`define OFS_STATUS      4'h4
`define OFS_RESULT      4'h8
`define OFS_SAMPLE      4'hC

// ****************************************
// Field positions
// ****************************************
`define CTRL_CLK_INT    0
`define CTRL_SOFT_START 1
`define CTRL_CS_MODE    2
`define STAT_BUSY       0
`define STAT_SENDING    1
`define STAT_FMT_LO     4

// ****************************************
// Reset values
// ****************************************
`define CTRL_RESET      3'h1
`define RESULT_RESET    14'h0000

// ****************************************
// Format select encodings of the three-level input
// ****************************************
`define FMT_BYTE        2'h0
`define FMT_PARALLEL    2'h1
`define FMT_CONT        2'h2

// ****************************************
// Timing
// ****************************************
`define OSC_PERIOD_NS   40
`define CLK_PERIOD_NS   10
`define OSC_DIV_CYCLES  ((`OSC_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_TICKS      5'h10
`define RESULT_BITS     14

`endif

// >>> common/adc_port_pkg.sv
// Types for the converter start and output port.
// Assumes the constants header is compiled alongside.
package adc_port_pkg;

  // ****************************************
  // State machines
  // ****************************************
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b01,
    CONV_RUN  = 2'b10
  } conv_state_e;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_SEND = 2'b10
  } ser_state_e;

  typedef logic [13:0] result_t;

endpackage

// >>> verilog/adc_port.sv
// Start logic, conversion sequencer and parallel, byte and serial output pins.
// Assumes host pins are synchronous to MCLK except the convert-start edge,
// and a sample value supplied by the analog front end on SAMPLE_IN.
`include "adc_port_cfg.svh"

// Function
// - Rising convert-start edge puts track-and-hold into hold and starts a conversion.
// - Convert-start may arrive any time; it passes an internal synchroniser.
// - With convert-start tied low, select falling starts a conversion.
// - Data pins drive only while select and read strobe are both low, except frame, serial clock and serial data pins 12, 11, 10.
// - Active-low status output reports converter state.
// - Conversion clock is external clock input or internal oscillator.
// - Parallel format puts result bits 13, 12, 11 on their own pins.
// - Byte or serial format turns the bit 13 pin into high-byte select.
// - High-byte select low gives the lower result byte.
// - High-byte select high gives the upper result byte.
// - Serial format gives an active-low frame output that is driven at all times outside reset.
// - Serial format outputs a gated or continuous serial clock from the conversion clock.
// - Format select at negative level keeps serial clock running.
// - Format select at ground floats serial clock after each transmission.
// - Format select chooses parallel, byte with gated clock, or continuous clock.
// - High byte reads bits 7 and 6 low, 5 to 0 as bits 13 to 8.
module adc_port
  import adc_port_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST,
  // Host control pins
  input  wire logic        CONVERT_START_IN,
  input  wire logic        SELECT_N,
  input  wire logic        READ_STROBE_N,
  input  wire logic [1:0]  FORMAT_SELECT,
  input  wire logic        EXT_CLK_IN,
  input  wire logic        MSB_OR_BYTE_SELECT_PIN_I,
  // Analog front end value, two's complement
  input  wire logic [13:0] SAMPLE_IN,
  // Data pins, bit 12 doubles as frame, bit 11 as serial clock, bit 10 as serial data
  output logic      [13:0] DATA_O,
  output logic      [13:0] DATA_OE_N,
  // Status
  output logic             BUSY_INT_N,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST
);

  // ****************************************
  // Declarations
  // ****************************************
  conv_state_e conv_state_reg;
  ser_state_e  ser_state_reg;
  logic [2:0]  ctrl_reg;
  logic        soft_start_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        convert_start_in_s1_reg, convert_start_in_s2_reg, convert_start_in_s3_reg;
  logic        sel_s1_reg, sel_s2_reg, sel_s3_reg;
  logic        ext_clk_reg;
  logic [7:0]  osc_cnt_reg;
  logic        conv_tick;
  logic [4:0]  tick_cnt_reg;
  result_t     sample_reg;
  result_t     result_reg;
  result_t     shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic        sclk_reg;
  logic        serial_result_out_reg;
  logic        start_evt;
  logic        par, rd_en, hbs;
  logic [13:0] data_next, oe_n_next;
  logic [13:0] data_reg, oe_n_reg;

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // One wait state: data is ready at the edge where waitrequest is low
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
  assign AVS_READDATA    = rdata_reg;

  // Acknowledge and read data
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg   <= (AVS_READ | AVS_WRITE) & ~ack_reg;
      rdata_reg <= 32'h00000000;
      if (AVS_READ && !ack_reg) begin
        case (AVS_ADDRESS)
          `OFS_CTRL:   rdata_reg <= {29'h00000000, ctrl_reg};
          `OFS_STATUS: rdata_reg <= {26'h0000000, FORMAT_SELECT, 2'h0,
                                     ser_state_reg == SER_SEND, ~BUSY_INT_N};
          `OFS_RESULT: rdata_reg <= {18'h00000, result_reg};
          `OFS_SAMPLE: rdata_reg <= {18'h00000, sample_reg};
          default:     rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // Control register; the soft-start bit is a self-clearing pulse.
  // Write lands only on the edge that completes the transfer (waitrequest low)
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_reg       <= `CTRL_RESET;
      soft_start_reg <= 1'b0;
    end else begin
      soft_start_reg <= 1'b0;
      if (AVS_WRITE && ack_reg && AVS_ADDRESS == `OFS_CTRL && AVS_BYTEENABLE[0]) begin
        ctrl_reg       <= {AVS_WRITEDATA[`CTRL_CS_MODE], 1'b0, AVS_WRITEDATA[`CTRL_CLK_INT]};
        soft_start_reg <= AVS_WRITEDATA[`CTRL_SOFT_START];
      end
    end
  end

  // ****************************************
  // Start detection
  // ****************************************
  // Two-flop synchronisers; third stage only feeds edge detection
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      convert_start_in_s1_reg <= 1'b0;
      convert_start_in_s2_reg <= 1'b0;
      convert_start_in_s3_reg <= 1'b0;
      sel_s1_reg    <= 1'b1;
      sel_s2_reg    <= 1'b1;
      sel_s3_reg    <= 1'b1;
    end else begin
      convert_start_in_s1_reg <= CONVERT_START_IN;
      convert_start_in_s2_reg <= convert_start_in_s1_reg;
      convert_start_in_s3_reg <= convert_start_in_s2_reg;
      sel_s1_reg    <= SELECT_N;
      sel_s2_reg    <= sel_s1_reg;
      sel_s3_reg    <= sel_s2_reg;
    end
  end

  // Host keeps select high during the pulse, so both sources never collide
  assign start_evt = (convert_start_in_s2_reg & ~convert_start_in_s3_reg)
                   | (ctrl_reg[`CTRL_CS_MODE] & ~convert_start_in_s2_reg
                      & ~sel_s2_reg & sel_s3_reg)
                   | soft_start_reg;

  // ****************************************
  // Conversion clock
  // ****************************************
  // Internal oscillator is a divider; the external clock is edge detected
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      osc_cnt_reg <= 8'h00;
      ext_clk_reg <= 1'b0;
    end else begin
      ext_clk_reg <= EXT_CLK_IN;
      if (osc_cnt_reg == 8'(`OSC_DIV_CYCLES - 1)) begin
        osc_cnt_reg <= 8'h00;
      end else begin
        osc_cnt_reg <= osc_cnt_reg + 8'h01;
      end
    end
  end

  assign conv_tick = ctrl_reg[`CTRL_CLK_INT] ? (osc_cnt_reg == 8'(`OSC_DIV_CYCLES - 1))
                                             : (EXT_CLK_IN & ~ext_clk_reg);

  // ****************************************
  // Conversion sequencer
  // ****************************************
  // Starts while busy are ignored; the held sample must not be disturbed
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      conv_state_reg <= CONV_IDLE;
      tick_cnt_reg   <= 5'h00;
      sample_reg     <= `RESULT_RESET;
      result_reg     <= `RESULT_RESET;
    end else begin
      case (conv_state_reg)
        CONV_IDLE: begin
          if (start_evt) begin
            conv_state_reg <= CONV_RUN;
            sample_reg     <= SAMPLE_IN;  // Hold
            tick_cnt_reg   <= `CONV_TICKS;
          end
        end
        CONV_RUN: begin
          if (conv_tick) begin
            if (tick_cnt_reg == 5'h01) begin
              conv_state_reg <= CONV_IDLE;
              result_reg     <= sample_reg; // Two's complement kept as is
            end
            tick_cnt_reg <= tick_cnt_reg - 5'h01;
          end
        end
        default: conv_state_reg <= CONV_IDLE;
      endcase
    end
  end

  // Low while converting, released when the result is loaded
  assign BUSY_INT_N = (conv_state_reg != CONV_RUN);

  // ****************************************
  // Serial transmitter
  // ****************************************
  // Bits change on rising serial clock so they are stable at the falling edge
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ser_state_reg <= SER_IDLE;
      sclk_reg      <= 1'b0;
      serial_result_out_reg     <= 1'b0;
      shift_reg     <= `RESULT_RESET;
      bit_cnt_reg   <= 4'h0;
    end else begin
      if (conv_tick) begin
        sclk_reg <= ~sclk_reg; // Derived from the conversion clock
      end
      case (ser_state_reg)
        SER_IDLE: begin
          if (conv_tick && !sclk_reg && !par && $fell(BUSY_INT_N) == 1'b0
              && shift_reg != result_reg) begin
            ser_state_reg <= SER_SEND;
            serial_result_out_reg     <= result_reg[13];
            shift_reg     <= result_reg;
            bit_cnt_reg   <= 4'(`RESULT_BITS - 1);
          end
        end
        SER_SEND: begin
          if (conv_tick && !sclk_reg) begin
            if (bit_cnt_reg == 4'h0) begin
              ser_state_reg <= SER_IDLE;
            end else begin
              serial_result_out_reg   <= shift_reg[bit_cnt_reg - 4'h1];
              bit_cnt_reg <= bit_cnt_reg - 4'h1;
            end
          end
        end
        default: ser_state_reg <= SER_IDLE;
      endcase
    end
  end

  // ****************************************
  // Pin multiplexing
  // ****************************************
  assign par   = (FORMAT_SELECT == `FMT_PARALLEL);
  assign rd_en = ~SELECT_N & ~READ_STROBE_N;
  assign hbs   = MSB_OR_BYTE_SELECT_PIN_I;

  // Next pin values; output enables are active low
  always_comb begin
    data_next = 14'h0000;
    oe_n_next = 14'h3FFF;
    if (par) begin
      data_next = result_reg;
      oe_n_next = {14{~rd_en}};
    end else begin
      data_next[7:0] = hbs ? {2'b00, result_reg[13:8]}
                           : result_reg[7:0];
      oe_n_next[7:0] = {8{~rd_en}};
      data_next[12]  = ser_state_reg != SER_SEND;      // Frame, active low
      oe_n_next[12]  = 1'b0;
      data_next[11]  = sclk_reg;
      // Continuous clock drives always, gated clock floats between words
      oe_n_next[11]  = (FORMAT_SELECT == `FMT_CONT) ? 1'b0
                                                    : ser_state_reg != SER_SEND;
      data_next[10]  = serial_result_out_reg;
      oe_n_next[10]  = ser_state_reg != SER_SEND;
    end
  end

  // Registered pins
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      data_reg <= 14'h0000;
      oe_n_reg <= 14'h3FFF;
    end else begin
      data_reg <= data_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign DATA_O    = data_reg;
  assign DATA_OE_N = oe_n_reg;

  // ****************************************
  // Assertions
  // ****************************************
  AST_START_HOLD: assert property (@(posedge MCLK) disable iff (RST)
    (convert_start_in_s2_reg && !convert_start_in_s3_reg && conv_state_reg == CONV_IDLE)
      |=> (!BUSY_INT_N && sample_reg == $past(SAMPLE_IN)))
    else $error("Convert-start edge did not start a conversion");

  AST_SYNC_DELAY: assert property (@(posedge MCLK) disable iff (RST)
    $rose(convert_start_in_s2_reg) |-> $past(CONVERT_START_IN, 2))
    else $error("Convert-start not passed through two stages");

  AST_SELECT_START: assert property (@(posedge MCLK) disable iff (RST)
    (ctrl_reg[`CTRL_CS_MODE] && !convert_start_in_s2_reg && !sel_s2_reg && sel_s3_reg
     && BUSY_INT_N) |=> !BUSY_INT_N)
    else $error("Select falling edge did not start a conversion");

  AST_BUS_ENABLE: assert property (@(posedge MCLK) disable iff (RST)
    ##1 DATA_OE_N[7:0] == {8{!$past(rd_en)}})
    else $error("Byte lanes driven outside select and read");

  AST_PARALLEL_MSB: assert property (@(posedge MCLK) disable iff (RST)
    (par && rd_en) |=> DATA_O[13:11] == $past(result_reg[13:11]) && DATA_OE_N[13:11] == 3'h0)
    else $error("Parallel top bits wrong");

  AST_LOW_BYTE: assert property (@(posedge MCLK) disable iff (RST)
    (!par && !hbs && rd_en) |=> DATA_O[7:0] == $past(result_reg[7:0]))
    else $error("Low byte wrong");

  AST_HIGH_BYTE: assert property (@(posedge MCLK) disable iff (RST)
    (!par && hbs && rd_en) |=> DATA_O[7:0] == {2'b00, $past(result_reg[13:8])})
    else $error("High byte wrong");

  AST_CONV_END: assert property (@(posedge MCLK) disable iff (RST)
    (!BUSY_INT_N && conv_tick && tick_cnt_reg == 5'h01)
      |=> BUSY_INT_N && result_reg == $past(sample_reg))
    else $error("Status not released with new result");

  AST_SCLK_CONT: assert property (@(posedge MCLK) disable iff (RST)
    (FORMAT_SELECT == `FMT_CONT) |=> !DATA_OE_N[11])
    else $error("Continuous serial clock not driven");

  AST_SCLK_GATED: assert property (@(posedge MCLK) disable iff (RST)
    (FORMAT_SELECT == `FMT_BYTE && ser_state_reg == SER_IDLE) |=> DATA_OE_N[11])
    else $error("Gated serial clock driven while idle");

  AST_FRAME_FIRST: assert property (@(posedge MCLK) disable iff (RST)
    $rose(ser_state_reg == SER_SEND) |-> serial_result_out_reg == shift_reg[13] ##1 !DATA_O[12])
    else $error("Frame or first serial bit wrong");

  COV_CONVERT: cover property (@(posedge MCLK) disable iff (RST)
    $rose(BUSY_INT_N));
  COV_SERIAL: cover property (@(posedge MCLK) disable iff (RST)
    $fell(ser_state_reg == SER_SEND));
  COV_HIGH_READ: cover property (@(posedge MCLK) disable iff (RST)
    !par && hbs && rd_en);

endmodule
